/* fmcs_top.sv */
// Master configuration and status registers behind an AXI4-Lite slave.
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/10ps

// How it works
// - SDH format drives every trace byte slot with the transmit trace byte.
// - SONET format numbers trace slots upward from 1 to N.
// - SDH plus trace buffer enable replaces only the first trace slot.
// - Path FEBE enabled gives one path FEBE per path BIP error.
// - Path FEBE disabled gives no path FEBE from BIP errors.
// - Line FEBE enabled gives one line FEBE per line BIP error.
// - Line FEBE disabled gives no line FEBE from BIP errors.
// - Auto path RDI inserts path RDI on any enabled path alarm.
// - Auto line RDI inserts line RDI on any enabled line alarm.
// - Path diagnostic loopback feeds transmit path into receive path.
// - Loop timing picks recovered clock, otherwise synthesized clock.
// - Serial diagnostic loopback routes transmit serial into receive.
// - Line loopback in 622.08 Mbit/s mode returns received data.
// - Clock activity bits set on rising edges, whole register clears on read.
// - Clock activity bits 7,6,5,4,2,1,0 map the seven monitored clocks.
// - Summary register shows read-only per-block interrupt requests.
// - Reading the summary acknowledges nothing; blocks clear their own.
// - Summary bit is high only while its block has an enabled request.
// - Writable bits reset to zero except the four auto enables.
module fmcs_top #(
  parameter int ADDR_W = 12,
  parameter int STS_N = 12,
  parameter int ALARM_W = 8
) (
  input wire logic clk, // 10 MHz register clock
  input wire logic srst, // synchronous reset, active high
  input wire logic ce, // clock enable, freezes all state when low
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire fmcs_pkg::fmcs_mon_clk_s mon_clocks, // monitored clocks
  input wire fmcs_pkg::fmcs_irq_s block_irq, // enabled block requests
  input wire logic path_bip_err_evt, // path BIP error pulse
  input wire logic line_bip_err_evt, // line BIP error pulse
  input wire logic [ALARM_W-1:0] path_alarm, // declared path alarms
  input wire logic [ALARM_W-1:0] path_alarm_rdi_en, // path RDI enables
  input wire logic [ALARM_W-1:0] line_alarm, // declared line alarms
  input wire logic [ALARM_W-1:0] line_alarm_rdi_en, // line RDI enables
  input wire logic serial_622_mode, // serial line interface selected
  input wire logic [$clog2(STS_N)-1:0] trace_slot, // trace slot, 0 first
  input wire logic [7:0] trace_buffer_byte, // byte from trace buffer
  output logic [7:0] trace_byte, // trace byte to insert
  output logic path_febe_insert, // one pulse per path FEBE
  output logic line_febe_insert, // one pulse per line FEBE
  output logic path_rdi_insert, // path RDI insert level
  output logic line_rdi_insert, // line RDI insert level
  output fmcs_pkg::fmcs_loop_s loop_ctrl, // loopback and timing
  output logic irq_out_n // interrupt, active low
);

  localparam int SLOT_W = $clog2(STS_N);

  typedef struct packed {
    logic awready;
    logic wready;
    logic arready;
    logic bvalid;
    logic rvalid;
    logic [1:0] bresp;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic aw_held;
    logic w_held;
    logic [fmcs_pkg::IDX_W-1:0] aw_idx;
    logic [7:0] wbyte;
    logic wlane;
    logic trace_format_sdh_select;
    logic tx_trace_buffer_enable;
    logic [7:0] tx_trace_value;
    logic [7:0] master_config_two;
    logic [7:0] clk_sync1;
    logic [7:0] clk_sync2;
    logic [7:0] clk_prev;
    logic [7:0] clock_activity_monitor;
    logic [7:0] block_interrupt_summary;
    logic irq_n;
    fmcs_pkg::fmcs_loop_s loop;
    logic path_febe;
    logic line_febe;
    logic path_rdi;
    logic line_rdi;
    logic [7:0] trace_out;
  } fmcs_state_s;

  // The reset state is spelled out field by field; only the automatic
  // insertion enables and the released interrupt output start high.
  localparam fmcs_state_s STATE_RESET = '{
    awready: 1'h0,
    wready: 1'h0,
    arready: 1'h0,
    bvalid: 1'h0,
    rvalid: 1'h0,
    bresp: fmcs_pkg::RESP_OKAY,
    rresp: fmcs_pkg::RESP_OKAY,
    rdata: 32'h00000000,
    aw_held: 1'h0,
    w_held: 1'h0,
    aw_idx: '0,
    wbyte: 8'h00,
    wlane: 1'h0,
    trace_format_sdh_select: 1'h0,
    tx_trace_buffer_enable: 1'h0,
    tx_trace_value: 8'h00,
    master_config_two: fmcs_pkg::MC2_RESET,
    clk_sync1: 8'h00,
    clk_sync2: 8'h00,
    clk_prev: 8'h00,
    clock_activity_monitor: 8'h00,
    block_interrupt_summary: 8'h00,
    irq_n: 1'h1,
    loop: '0,
    path_febe: 1'h0,
    line_febe: 1'h0,
    path_rdi: 1'h0,
    line_rdi: 1'h0,
    trace_out: 8'h00
  };

  fmcs_state_s q;
  fmcs_state_s next_q;

  // Index of a byte address; word offset drops the two low bits.
  function automatic logic [fmcs_pkg::IDX_W-1:0] to_idx(
    input logic [ADDR_W-1:0] addr
  );
    to_idx = addr[fmcs_pkg::IDX_W+1:2];
  endfunction

  // Index bit 8 steers to the test space, which this block leaves unmapped.
  function automatic logic in_test_space(
    input logic [fmcs_pkg::IDX_W-1:0] idx
  );
    in_test_space = idx[fmcs_pkg::TEST_REG_SELECT_BIT];
  endfunction

  // Normal-mode space only; the test bit steers to unmapped space.
  function automatic logic is_mapped(
    input logic [fmcs_pkg::IDX_W-1:0] idx
  );
    is_mapped = !in_test_space(idx) &&
      (idx == fmcs_pkg::IDX_MASTER_CONFIG_ONE ||
       idx == fmcs_pkg::IDX_MASTER_CONFIG_TWO ||
       idx == fmcs_pkg::IDX_CLOCK_ACTIVITY ||
       idx == fmcs_pkg::IDX_BLOCK_IRQ_SUMMARY ||
       idx == fmcs_pkg::IDX_TX_TRACE_BYTE ||
       idx == fmcs_pkg::IDX_TRACE_BUFFER_CTRL);
  endfunction

  always_comb begin
    logic [fmcs_pkg::IDX_W-1:0] ridx;
    logic [7:0] rbyte;
    logic [7:0] edges;
    logic [7:0] mc2;
    next_q = q;
    ridx = to_idx(s_axi_araddr);
    rbyte = 8'h00;
    mc2 = q.master_config_two;
    edges = 8'h00;

    // ****************************************************
    // Write channel: address and data in either order.
    // ****************************************************
    // The held flags let address and data land on separate edges; the
    // price is one extra cycle before the write response.
    if (q.awready && s_axi_awvalid) begin
      next_q.aw_held = 1'b1;
      next_q.aw_idx = to_idx(s_axi_awaddr);
    end
    if (q.wready && s_axi_wvalid) begin
      next_q.w_held = 1'b1;
      next_q.wbyte = s_axi_wdata[7:0];
      next_q.wlane = s_axi_wstrb[0];
    end
    if (q.bvalid && s_axi_bready) begin
      next_q.bvalid = 1'b0;
    end
    if (q.aw_held && q.w_held && !q.bvalid) begin
      next_q.aw_held = 1'b0;
      next_q.w_held = 1'b0;
      next_q.bvalid = 1'b1;
      next_q.bresp = is_mapped(q.aw_idx) ? fmcs_pkg::RESP_OKAY :
        fmcs_pkg::RESP_SLVERR;
      if (q.wlane && !in_test_space(q.aw_idx)) begin
        case (q.aw_idx)
          fmcs_pkg::IDX_MASTER_CONFIG_ONE: begin
            next_q.trace_format_sdh_select =
              q.wbyte[fmcs_pkg::MC1_TRACE_FORMAT_SDH_SELECT];
          end
          fmcs_pkg::IDX_MASTER_CONFIG_TWO: begin
            next_q.master_config_two = q.wbyte;
          end
          fmcs_pkg::IDX_TX_TRACE_BYTE: begin
            next_q.tx_trace_value = q.wbyte;
          end
          fmcs_pkg::IDX_TRACE_BUFFER_CTRL: begin
            next_q.tx_trace_buffer_enable =
              q.wbyte[fmcs_pkg::TBUF_TX_TRACE_BUFFER_ENABLE];
          end
          default: begin
            // Read-only and clear-on-read registers ignore writes.
          end
        endcase
      end
    end
    next_q.awready = !next_q.aw_held && !next_q.bvalid;
    next_q.wready = !next_q.w_held && !next_q.bvalid;

    // ****************************************************
    // Read channel.
    // ****************************************************
    // One read at a time: arready stays low while an answer waits, so a
    // clear-on-read register is cleared once per answer.
    if (q.rvalid && s_axi_rready) begin
      next_q.rvalid = 1'b0;
    end
    if (q.arready && s_axi_arvalid) begin
      case (ridx)
        fmcs_pkg::IDX_MASTER_CONFIG_ONE: begin
          rbyte[fmcs_pkg::MC1_TRACE_FORMAT_SDH_SELECT] =
            q.trace_format_sdh_select;
        end
        fmcs_pkg::IDX_MASTER_CONFIG_TWO: begin
          rbyte = q.master_config_two;
        end
        fmcs_pkg::IDX_CLOCK_ACTIVITY: begin
          rbyte = q.clock_activity_monitor;
          // Whole register clears; edges below may set it again.
          next_q.clock_activity_monitor = 8'h00;
        end
        fmcs_pkg::IDX_BLOCK_IRQ_SUMMARY: begin
          // A plain read; requests are acknowledged in their blocks.
          rbyte = q.block_interrupt_summary;
        end
        fmcs_pkg::IDX_TX_TRACE_BYTE: begin
          rbyte = q.tx_trace_value;
        end
        fmcs_pkg::IDX_TRACE_BUFFER_CTRL: begin
          rbyte[fmcs_pkg::TBUF_TX_TRACE_BUFFER_ENABLE] =
            q.tx_trace_buffer_enable;
        end
        default: begin
          rbyte = 8'h00;
        end
      endcase
      if (in_test_space(ridx)) begin
        rbyte = 8'h00;
      end
      next_q.rvalid = 1'b1;
      next_q.rdata = {24'h000000, rbyte};
      next_q.rresp = is_mapped(ridx) ? fmcs_pkg::RESP_OKAY :
        fmcs_pkg::RESP_SLVERR;
    end
    next_q.arready = !next_q.rvalid;

    // ****************************************************
    // Clock activity monitor.
    // ****************************************************
    // A monitored clock is seen only if each level lasts longer than a
    // register clock period; a faster clock must be divided down before
    // it reaches this block.
    // Edge detection reads only the second stage of each synchroniser.
    next_q.clk_sync1 = mon_clocks & fmcs_pkg::CLOCK_ACTIVITY_MASK;
    next_q.clk_sync2 = q.clk_sync1;
    next_q.clk_prev = q.clk_sync2;
    edges = q.clk_sync2 & ~q.clk_prev & fmcs_pkg::CLOCK_ACTIVITY_MASK;
    // Setting after the read clear keeps an edge that meets a read.
    next_q.clock_activity_monitor =
      next_q.clock_activity_monitor | edges;

    // ****************************************************
    // Interrupt summary and output.
    // ****************************************************
    next_q.block_interrupt_summary =
      {1'b0, block_irq} & fmcs_pkg::IRQ_SUMMARY_MASK;
    // The output lags the requests by two cycles, one behind the summary.
    next_q.irq_n = ~|q.block_interrupt_summary;

    // ****************************************************
    // Automatic FEBE and RDI insertion.
    // ****************************************************
    // Each error pulse gives its own insert pulse, so back-to-back errors
    // are never merged into a single FEBE.
    next_q.path_febe = path_bip_err_evt &&
      mc2[fmcs_pkg::MC2_AUTO_PATH_FEBE_EN];
    next_q.line_febe = line_bip_err_evt &&
      mc2[fmcs_pkg::MC2_AUTO_LINE_FEBE_EN];
    next_q.path_rdi = mc2[fmcs_pkg::MC2_AUTO_PATH_RDI_EN] &&
      |(path_alarm & path_alarm_rdi_en);
    next_q.line_rdi = mc2[fmcs_pkg::MC2_AUTO_LINE_RDI_EN] &&
      |(line_alarm & line_alarm_rdi_en);

    // ****************************************************
    // Loopbacks and transmit timing.
    // ****************************************************
    // Conflicting loopback settings are passed on as written; software
    // is expected to keep them exclusive.
    next_q.loop.path_diag_loopback =
      mc2[fmcs_pkg::MC2_PATH_DIAG_LOOPBACK_EN];
    next_q.loop.serial_diag_loopback =
      mc2[fmcs_pkg::MC2_SERIAL_DIAG_LOOPBACK_EN];
    next_q.loop.serial_line_loopback = serial_622_mode &&
      mc2[fmcs_pkg::MC2_SERIAL_LINE_LOOPBACK_EN];
    next_q.loop.loop_timing_select =
      mc2[fmcs_pkg::MC2_LOOP_TIMING_SELECT];

    // ****************************************************
    // Section trace byte generation.
    // ****************************************************
    // The slot index is sampled with the byte, so the caller presents each
    // slot one cycle before its byte is due.
    if (q.trace_format_sdh_select) begin
      if (q.tx_trace_buffer_enable && trace_slot == {SLOT_W{1'b0}}) begin
        next_q.trace_out = trace_buffer_byte;
      end else begin
        next_q.trace_out = q.tx_trace_value;
      end
    end else begin
      next_q.trace_out = 8'(trace_slot) + fmcs_pkg::SONET_TRACE_FIRST;
    end
  end

  // A low clock enable freezes the bus handshakes too; a master must not
  // time out while the enable is held low.
  always_ff @(posedge clk) begin
    if (srst) begin
      q <= STATE_RESET;
    end else if (ce) begin
      q <= next_q;
    end
  end

  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rresp = q.rresp;
  assign s_axi_rdata = q.rdata;
  assign trace_byte = q.trace_out;
  assign path_febe_insert = q.path_febe;
  assign line_febe_insert = q.line_febe;
  assign path_rdi_insert = q.path_rdi;
  assign line_rdi_insert = q.line_rdi;
  assign loop_ctrl = q.loop;
  assign irq_out_n = q.irq_n;

endmodule

/* fmcs_pkg.sv */
// Shared constants and carrier types of the framer master config block.
package fmcs_pkg;

  // ****************************************************
  // Register indices; byte address is four times these.
  // ****************************************************
  localparam int IDX_W = 10;
  localparam logic [9:0] IDX_MASTER_CONFIG_ONE = 10'h001;
  localparam logic [9:0] IDX_MASTER_CONFIG_TWO = 10'h002;
  localparam logic [9:0] IDX_CLOCK_ACTIVITY = 10'h003;
  localparam logic [9:0] IDX_BLOCK_IRQ_SUMMARY = 10'h004;
  localparam logic [9:0] IDX_TX_TRACE_BYTE = 10'h0F8;
  localparam logic [9:0] IDX_TRACE_BUFFER_CTRL = 10'h0F9;
  localparam int TEST_REG_SELECT_BIT = 8;

  // ****************************************************
  // Field positions.
  // ****************************************************
  localparam int MC1_TRACE_FORMAT_SDH_SELECT = 5;
  localparam int MC2_SERIAL_LINE_LOOPBACK_EN = 7;
  localparam int MC2_SERIAL_DIAG_LOOPBACK_EN = 6;
  localparam int MC2_LOOP_TIMING_SELECT = 5;
  localparam int MC2_PATH_DIAG_LOOPBACK_EN = 4;
  localparam int MC2_AUTO_LINE_RDI_EN = 3;
  localparam int MC2_AUTO_PATH_RDI_EN = 2;
  localparam int MC2_AUTO_LINE_FEBE_EN = 1;
  localparam int MC2_AUTO_PATH_FEBE_EN = 0;
  localparam int TBUF_TX_TRACE_BUFFER_ENABLE = 0;

  // ****************************************************
  // Reset values and masks.
  // ****************************************************
  localparam logic [7:0] MC2_RESET = 8'h0F;
  localparam logic [7:0] CLOCK_ACTIVITY_MASK = 8'hF7;
  localparam logic [7:0] IRQ_SUMMARY_MASK = 8'h7F;
  localparam logic [7:0] SONET_TRACE_FIRST = 8'h01;

  // ****************************************************
  // AXI4-Lite answers.
  // ****************************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Monitored clocks, packed in clock activity bit order.
  typedef struct packed {
    logic tx_line_clock;
    logic rx_line_clock;
    logic rx_system_clock;
    logic tx_system_clock;
    logic spare;
    logic synth_reference_clock;
    logic parallel_rx_clock;
    logic parallel_tx_clock;
  } fmcs_mon_clk_s;

  // Block interrupt requests, packed in summary bit order.
  typedef struct packed {
    logic concat_irq_pending;
    logic alarm_ber_irq_pending;
    logic tx_cell_irq_pending;
    logic rx_cell_irq_pending;
    logic rx_path_irq_pending;
    logic rx_line_irq_pending;
    logic rx_section_irq_pending;
  } fmcs_irq_s;

  // Loopback and timing controls toward the datapath.
  typedef struct packed {
    logic path_diag_loopback;
    logic serial_diag_loopback;
    logic serial_line_loopback;
    logic loop_timing_select;
  } fmcs_loop_s;

endpackage

/* fmcs_chk.sv */
// Port checker for the framer master config and status block.
`timescale 1ns/10ps

// ****************************************************
// Checker module
// ****************************************************
module fmcs_chk #(
  parameter int ADDR_W = 12,
  parameter int ALARM_W = 8
) (
  input wire logic clk, // register clock
  input wire logic srst, // synchronous reset
  input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  input wire logic s_axi_arready, // read address ready
  input wire logic [31:0] s_axi_rdata, // read data
  input wire logic [1:0] s_axi_rresp, // read response
  input wire logic s_axi_rvalid, // read valid
  input wire fmcs_pkg::fmcs_irq_s block_irq, // block requests
  input wire logic path_bip_err_evt, // path error pulse
  input wire logic line_bip_err_evt, // line error pulse
  input wire logic [ALARM_W-1:0] path_alarm, // path alarms
  input wire logic [ALARM_W-1:0] path_alarm_rdi_en, // path enables
  input wire logic [ALARM_W-1:0] line_alarm, // line alarms
  input wire logic [ALARM_W-1:0] line_alarm_rdi_en, // line enables
  input wire logic serial_622_mode, // serial line mode
  input wire logic path_febe_insert, // path FEBE pulse
  input wire logic line_febe_insert, // line FEBE pulse
  input wire logic path_rdi_insert, // path RDI level
  input wire logic line_rdi_insert, // line RDI level
  input wire fmcs_pkg::fmcs_loop_s loop_ctrl, // loopbacks
  input wire logic irq_out_n // interrupt, active low
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  AST_PATH_FEBE: assert property (
    path_febe_insert |-> $past(path_bip_err_evt))
    else $error("path FEBE pulse without a path BIP error");
  AST_LINE_FEBE: assert property (
    line_febe_insert |-> $past(line_bip_err_evt))
    else $error("line FEBE pulse without a line BIP error");
  AST_PATH_RDI: assert property (
    !(|(path_alarm & path_alarm_rdi_en)) |=> !path_rdi_insert)
    else $error("path RDI with no enabled path alarm");
  AST_LINE_RDI: assert property (
    !(|(line_alarm & line_alarm_rdi_en)) |=> !line_rdi_insert)
    else $error("line RDI with no enabled line alarm");
  AST_IRQ_OUT: assert property (
    !$past(srst) && !$past(srst, 2) |->
    irq_out_n == !(|$past(block_irq, 2)))
    else $error("interrupt output does not follow block requests");
  AST_TEST_SPACE: assert property (
    s_axi_arvalid && s_axi_arready &&
    s_axi_araddr[fmcs_pkg::TEST_REG_SELECT_BIT+2] |=> s_axi_rvalid &&
    s_axi_rresp == fmcs_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("test space read not refused");
  AST_RDATA_HIGH: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data above bit 7 not zero");
  AST_LINE_LOOP: assert property (
    !serial_622_mode |=> !loop_ctrl.serial_line_loopback)
    else $error("line loopback outside serial line mode");

  COV_FEBE: cover property (path_febe_insert && line_febe_insert);
  COV_IRQ: cover property (!irq_out_n);
  COV_REFUSED: cover property (s_axi_rvalid && s_axi_rresp != 2'h0);
endmodule

bind fmcs_top fmcs_chk #(.ADDR_W(ADDR_W), .ALARM_W(ALARM_W)) fmcs_chk_inst (
  .clk(clk), .srst(srst), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .block_irq(block_irq),
  .path_bip_err_evt(path_bip_err_evt), .line_bip_err_evt(line_bip_err_evt),
  .path_alarm(path_alarm), .path_alarm_rdi_en(path_alarm_rdi_en),
  .line_alarm(line_alarm), .line_alarm_rdi_en(line_alarm_rdi_en),
  .serial_622_mode(serial_622_mode), .path_febe_insert(path_febe_insert),
  .line_febe_insert(line_febe_insert), .path_rdi_insert(path_rdi_insert),
  .line_rdi_insert(line_rdi_insert), .loop_ctrl(loop_ctrl),
  .irq_out_n(irq_out_n)
);

/* fmcs_top_test.sv */
// Self-checking testbench of the framer master config and status block.
`timescale 1ns/10ps

module fmcs_top_test;
  logic clk = 1'h0, srst = 1'h1, pbip = 1'h0, lbip = 1'h0, m622 = 1'h1;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic pfebe, lfebe, prdi, lrdi, irq_n;
  logic [11:0] awaddr = 12'h0, araddr = 12'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0] bresp, rresp;
  logic [7:0] palm = 8'h81, lalm = 8'h81, pen = 8'h0, len = 8'h0;
  logic [7:0] tbuf = 8'h3C, tbyte;
  logic [3:0] slot = 4'h0;
  fmcs_pkg::fmcs_mon_clk_s mon = '0;
  fmcs_pkg::fmcs_irq_s birq = '0;
  fmcs_pkg::fmcs_loop_s loopc;
  int fail_count = 0, comparisons = 0;

  always #50 clk = ~clk;

  fmcs_top fmcs_top_inst (
    .clk(clk), .srst(srst), .ce(1'h1),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .mon_clocks(mon),
    .block_irq(birq), .path_bip_err_evt(pbip), .line_bip_err_evt(lbip),
    .path_alarm(palm), .path_alarm_rdi_en(pen), .line_alarm(lalm),
    .line_alarm_rdi_en(len), .serial_622_mode(m622), .trace_slot(slot),
    .trace_buffer_byte(tbuf), .trace_byte(tbyte), .path_febe_insert(pfebe),
    .line_febe_insert(lfebe), .path_rdi_insert(prdi),
    .line_rdi_insert(lrdi), .loop_ctrl(loopc), .irq_out_n(irq_n)
  );

  // ****************************************************
  // Comparison, verdict and bus tasks
  // ****************************************************
  task automatic chk(input string name, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // The slave may take address and data on different edges, so each is
  // released on its own handshake.
  task automatic wr(input logic [11:0] a, input logic [7:0] v,
                    input logic [1:0] er);
    logic ad, dd;
    ad = 1'h0;
    dd = 1'h0;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h0, v};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!(ad && dd)) begin
      @(posedge clk);
      if (awready && !ad) begin
        ad = 1'h1;
        awvalid <= 1'h0;
      end
      if (wready && !dd) begin
        dd = 1'h1;
        wvalid <= 1'h0;
      end
    end
    while (bvalid !== 1'h1) @(posedge clk);
    bready <= 1'h0;
    chk("bresp", {30'h0, bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] ev,
                    input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge clk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    do @(posedge clk); while (rvalid !== 1'h1);
    rready <= 1'h0;
    chk("rdata", rdata, {24'h0, ev});
    chk("rresp", {30'h0, rresp}, {30'h0, er});
  endtask

  // ****************************************************
  // Scenarios
  // ****************************************************
  task automatic t_space();
    rd(12'h008, 8'h0F, fmcs_pkg::RESP_OKAY);
    rd(12'h004, 8'h00, fmcs_pkg::RESP_OKAY);
    rd(12'h3E4, 8'h00, fmcs_pkg::RESP_OKAY);
    wr(12'h408, 8'h00, fmcs_pkg::RESP_SLVERR);
    rd(12'h408, 8'h00, fmcs_pkg::RESP_SLVERR);
    rd(12'h014, 8'h00, fmcs_pkg::RESP_SLVERR);
    wr(12'h010, 8'hFF, fmcs_pkg::RESP_OKAY);
    rd(12'h010, 8'h00, fmcs_pkg::RESP_OKAY);
    rd(12'h008, 8'h0F, fmcs_pkg::RESP_OKAY);
  endtask

  // Events come back to back, so merged pulses would undercount.
  task automatic t_febe();
    logic [7:0] cfg;
    int pc, lc;
    for (int i = 0; i < 4; i++) begin
      cfg = 8'h0C + 8'(i);
      wr(12'h008, cfg, fmcs_pkg::RESP_OKAY);
      pc = 0;
      lc = 0;
      for (int k = 0; k < 8; k++) begin
        @(posedge clk);
        pbip <= (k < 3);
        lbip <= (k < 3);
        pc += int'(pfebe === 1'h1);
        lc += int'(lfebe === 1'h1);
      end
      chk("path_febe", 32'(pc), cfg[0] ? 32'h3 : 32'h0);
      chk("line_febe", 32'(lc), cfg[1] ? 32'h3 : 32'h0);
    end
  endtask

  task automatic t_rdi();
    logic [7:0] cfg, en;
    for (int i = 0; i < 5; i++) begin
      cfg = (i == 4) ? 8'h0C : {4'h0, 2'(i), 2'h0};
      en = (i == 4) ? 8'h02 : 8'h80;
      pen <= en;
      len <= en;
      wr(12'h008, cfg, fmcs_pkg::RESP_OKAY);
      repeat (2) @(posedge clk);
      chk("path_rdi", {31'h0, prdi}, {31'h0, cfg[2] & en[7]});
      chk("line_rdi", {31'h0, lrdi}, {31'h0, cfg[3] & en[7]});
    end
  endtask

  task automatic t_loop();
    int b;
    logic [3:0] exp;
    for (int i = 0; i < 5; i++) begin
      b = (i == 4) ? 7 : 4 + i;
      m622 <= (i != 4);
      exp = {b == 4, b == 6, b == 7 && i != 4, b == 5};
      wr(12'h008, 8'h01 << b, fmcs_pkg::RESP_OKAY);
      repeat (2) @(posedge clk);
      chk("loop_ctrl", {28'h0, loopc}, {28'h0, exp});
      rd(12'h008, 8'h01 << b, fmcs_pkg::RESP_OKAY);
    end
    m622 <= 1'h1;
  endtask

  task automatic tr(input logic [3:0] s, input logic [7:0] ev);
    @(posedge clk);
    slot <= s;
    repeat (2) @(posedge clk);
    chk("trace_byte", {24'h0, tbyte}, {24'h0, ev});
  endtask

  task automatic t_trace();
    tr(4'h0, 8'h01);
    tr(4'hB, 8'h0C);
    wr(12'h3E0, 8'hA5, fmcs_pkg::RESP_OKAY);
    wr(12'h004, 8'h20, fmcs_pkg::RESP_OKAY);
    tr(4'h3, 8'hA5);
    tr(4'h0, 8'hA5);
    wr(12'h3E4, 8'h01, fmcs_pkg::RESP_OKAY);
    tr(4'h0, 8'h3C);
    tr(4'h1, 8'hA5);
  endtask

  // Bit 3 is pulsed too: it has no clock behind it and must stay low.
  task automatic t_clkmon();
    rd(12'h00C, 8'h00, fmcs_pkg::RESP_OKAY);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      mon <= 8'h01 << i;
      repeat (2) @(posedge clk);
      mon <= '0;
      repeat (3) @(posedge clk);
      rd(12'h00C, (8'h01 << i) & 8'hF7, fmcs_pkg::RESP_OKAY);
      rd(12'h00C, 8'h00, fmcs_pkg::RESP_OKAY);
    end
    // An edge that lands on the clearing read must survive it.
    @(posedge clk);
    mon <= 8'h80;
    @(posedge clk);
    rd(12'h00C, 8'h00, fmcs_pkg::RESP_OKAY);
    rd(12'h00C, 8'h80, fmcs_pkg::RESP_OKAY);
    mon <= '0;
  endtask

  task automatic t_irq();
    for (int i = 0; i < 7; i++) begin
      @(posedge clk);
      birq <= 7'h01 << i;
      repeat (3) @(posedge clk);
      chk("irq_out_n", {31'h0, irq_n}, 32'h0);
      rd(12'h010, 8'h01 << i, fmcs_pkg::RESP_OKAY);
      rd(12'h010, 8'h01 << i, fmcs_pkg::RESP_OKAY);
      @(posedge clk);
      birq <= '0;
      repeat (3) @(posedge clk);
      chk("irq_out_n", {31'h0, irq_n}, 32'h1);
      rd(12'h010, 8'h00, fmcs_pkg::RESP_OKAY);
    end
  endtask

  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'h0;
    t_space();
    t_febe();
    t_rdi();
    t_loop();
    t_trace();
    t_clkmon();
    t_irq();
    test_done();
  end

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    test_done();
  end
endmodule
